//--- core/plc_pid_defines.vh
// Purpose: Constants for the controller supervisory block
// Assumes: 32-bit AHB-Lite word map, 25 MHz sys_clk
// Notes: Offsets are byte addresses
`ifndef PLC_PID_DEFINES_VH
`define PLC_PID_DEFINES_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_PID_ACTION_SELECT 8'h00
`define OFS_PID_SETPOINT 8'h04
`define OFS_PID_MEASURED 8'h08
`define OFS_PID_OUTPUT 8'h0C
`define OFS_PID_RUN_CONTROL 8'h10
`define OFS_FLASH_CLEAR 8'h14
`define OFS_CONFIG 8'h18
`define OFS_COEF_BOUNDS 8'h1C
`define OFS_SCAN_SETTING 8'h20
`define OFS_SCAN_STATUS 8'h24

// ----------------------------------------
// Codes and reset values
// ----------------------------------------
`define ACT_DISABLED 16'h0000
`define ACT_SP_MV 16'h03E8
`define ACT_DEV 16'h03F2
`define ACT_SP_MV_NOAPPLY 16'h07D0
`define ACT_DEV_NOAPPLY 16'h07DA
`define COEF_NONE 16'h270F
`define FLASH_CLEAR_KEY 16'h25E0
`define FLASH_REFUSED 16'h0001
`define FLASH_IDLE 16'h0000
`define SCAN_OVERRUN_CODE 16'h1392
`define PCT_MAX 16'h2710
`define PCT_MIN 16'hD8F0
`define RST_ACTION 16'h0000
`define RST_FLASH 16'h0000

// ----------------------------------------
// Timing (clock 25 MHz)
// ----------------------------------------
`define CLK_HZ 25000000
`define FLASH_ERASE_S 30
`define FLASH_ERASE_CYC (`FLASH_ERASE_S * `CLK_HZ)
`define SCAN_QUANTUM_MS 10
`define SCAN_QUANTUM_CYC (`SCAN_QUANTUM_MS * (`CLK_HZ / 1000))
`define SCAN_SETTING_UNIT_US 500

`endif

//--- core/pid_saturate.v
// Purpose: Clamp a signed operand into a signed range
// Assumes: lo_lim <= hi_lim
// Notes: Combinational
`timescale 1ns/1ps
`default_nettype none
module pid_saturate #(
    parameter W = 16
) (
    input wire [W-1:0] value_in,
    input wire [W-1:0] lo_lim,
    input wire [W-1:0] hi_lim,
    output reg [W-1:0] value_out
);
    // Saturate to the nearest bound
    always @* begin
        if ($signed(value_in) > $signed(hi_lim)) begin
            value_out = hi_lim;
        end else if ($signed(value_in) < $signed(lo_lim)) begin
            value_out = lo_lim;
        end else begin
            value_out = value_in;
        end
    end
endmodule // pid_saturate
`default_nettype wire

//--- core/scan_pacer.v
// Purpose: Constant-scan pacing, overrun and watchdog detection
// Assumes: scan_start/scan_end are pulses on sys_clk
// Notes: Period setting is in 0.5 ms units
`timescale 1ns/1ps
`default_nettype none
`include "plc_pid_defines.vh"
module scan_pacer #(
    parameter QUANTUM_CYC = `SCAN_QUANTUM_CYC,
    parameter CW = 32
) (
    input wire sys_clk,
    input wire rst_n,
    input wire [15:0] scan_setting,
    input wire [15:0] watchdog_quanta,
    input wire scan_enable,
    input wire scan_start,
    input wire scan_end,
    input wire err_clear,
    output reg scan_wait,
    output reg scan_overrun_error,
    output reg watchdog_error,
    output reg [CW-1:0] last_scan_cyc
);
    reg [CW-1:0] run_cnt_reg;
    reg [CW-1:0] wait_cnt_reg;
    reg running_reg;
    reg [15:0] quanta;
    wire [CW-1:0] period_cyc;
    wire [CW-1:0] wd_cyc;

    // Round 0.5 ms units up to 10 ms quanta, minimum one
    always @* begin
        quanta = (scan_setting + 16'h0013) / 16'h0014;
        if (quanta == 16'h0000) begin
            quanta = 16'h0001;
        end
    end
    assign period_cyc = quanta * QUANTUM_CYC[CW-1:0];
    assign wd_cyc = watchdog_quanta * QUANTUM_CYC[CW-1:0];

    // Scan timing; overrun drops padding, watchdog halts
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            run_cnt_reg <= {CW{1'b0}};
            wait_cnt_reg <= {CW{1'b0}};
            running_reg <= 1'b0;
            scan_wait <= 1'b0;
            scan_overrun_error <= 1'b0;
            watchdog_error <= 1'b0;
            last_scan_cyc <= {CW{1'b0}};
        end else begin
            if (err_clear) begin
                scan_overrun_error <= 1'b0;
            end
            if (scan_start && !watchdog_error) begin
                running_reg <= 1'b1;
                run_cnt_reg <= {CW{1'b0}};
                scan_wait <= 1'b0;
            end else if (running_reg) begin
                run_cnt_reg <= run_cnt_reg + 1'b1;
                if (wd_cyc != {CW{1'b0}} && run_cnt_reg >= wd_cyc) begin
                    watchdog_error <= 1'b1;
                    running_reg <= 1'b0;
                end else if (scan_end) begin
                    running_reg <= 1'b0;
                    last_scan_cyc <= run_cnt_reg + 1'b1;
                    if (scan_enable && run_cnt_reg + 1'b1 > period_cyc) begin
                        scan_overrun_error <= 1'b1;
                    end else if (scan_enable && !scan_overrun_error) begin
                        scan_wait <= 1'b1;
                        wait_cnt_reg <= period_cyc - run_cnt_reg - 1'b1;
                    end
                end
            end else if (scan_wait) begin
                if (wait_cnt_reg <= 1) begin
                    scan_wait <= 1'b0;
                end
                wait_cnt_reg <= wait_cnt_reg - 1'b1;
            end
        end
    end
endmodule // scan_pacer
`default_nettype wire

//--- core/plc_pid_flash_scan_ctrl.v
// Purpose: PID operand words, flash-clear sequencer, scan pacing
// Assumes: AHB-Lite slave, single word transfers, zero wait states
// Notes: PID arithmetic is outside; result enters on pid_result
//
// Design decisions made here: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "plc_pid_defines.vh"
module plc_pid_flash_scan_ctrl #(
    parameter ERASE_CYC = `FLASH_ERASE_CYC,
    parameter QUANTUM_CYC = `SCAN_QUANTUM_CYC
) (
    input wire sys_clk,
    input wire rst_n,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output wire hresp,
    output reg [31:0] hrdata,
    input wire pid_enable_input,
    input wire enable_terminal_assigned,
    input wire [1:0] controller_function_select,
    input wire flash_fault_at_boot,
    input wire flash_erase_done,
    input wire [15:0] pid_result,
    input wire pid_result_valid,
    input wire scan_start,
    input wire scan_end,
    output wire pid_run,
    output wire pid_reverse,
    output wire pid_deviation_mode,
    output wire pid_apply_to_freq,
    output wire [15:0] pid_reference,
    output wire [15:0] pid_feedback,
    output reg flash_erase_req,
    output reg write_disable_error,
    output wire scan_wait,
    output wire scan_overrun_error,
    output wire watchdog_error
);
    // ----------------------------------------
    // Register state
    // ----------------------------------------
    reg [15:0] pid_action_select_reg;
    reg [15:0] pid_setpoint_reg;
    reg [15:0] pid_measured_reg;
    reg [15:0] pid_output_reg;
    reg [15:0] pid_run_control_reg;
    reg [15:0] flash_clear_reg;
    reg [15:0] coef_a_reg;
    reg [15:0] coef_b_reg;
    reg [15:0] scan_setting_reg;
    reg [15:0] watchdog_quanta_reg;
    reg scan_enable_reg;
    reg err_clear_reg;
    reg erasing_reg;
    reg [31:0] erase_cnt_reg;
    reg [1:0] boot_cnt_reg;
    reg sync1_reg, sync2_reg;
    reg [1:0] sel_s1_reg, sel_s2_reg;
    reg fault_s1_reg, fault_s2_reg;
    reg done_s1_reg, done_s2_reg;
    reg wr_pend_reg;
    reg [7:0] wr_addr_reg;
    wire [31:0] last_scan_cyc;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    // Enable, function-select, boot-fault and erase-done levels pass two flops before use
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            sel_s1_reg <= 2'b00;
            sel_s2_reg <= 2'b00;
            fault_s1_reg <= 1'b0;
            fault_s2_reg <= 1'b0;
            done_s1_reg <= 1'b0;
            done_s2_reg <= 1'b0;
        end else begin
            sync1_reg <= pid_enable_input;
            sync2_reg <= sync1_reg;
            sel_s1_reg <= controller_function_select;
            sel_s2_reg <= sel_s1_reg;
            fault_s1_reg <= flash_fault_at_boot;
            fault_s2_reg <= fault_s1_reg;
            done_s1_reg <= flash_erase_done;
            done_s2_reg <= done_s1_reg;
        end
    end

    // ----------------------------------------
    // PID mode decode
    // ----------------------------------------
    wire [15:0] act_base = {pid_action_select_reg[15:1], 1'b0};
    wire act_sp = act_base == `ACT_SP_MV || act_base == `ACT_SP_MV_NOAPPLY;
    wire act_dev = act_base == `ACT_DEV || act_base == `ACT_DEV_NOAPPLY;
    wire pid_enabled = act_sp || act_dev;
    assign pid_deviation_mode = act_dev;
    assign pid_reverse = ~pid_action_select_reg[0];
    assign pid_apply_to_freq = act_base == `ACT_SP_MV || act_base == `ACT_DEV;
    // Terminal gates the start only when it is assigned
    assign pid_run = pid_enabled && pid_run_control_reg[0]
        && (!enable_terminal_assigned || sync2_reg);

    // ----------------------------------------
    // Operand ranges and saturation
    // ----------------------------------------
    wire coef_mode = coef_a_reg != `COEF_NONE && coef_b_reg != `COEF_NONE;
    wire a_small = $signed(coef_a_reg) < $signed(coef_b_reg);
    wire [15:0] coef_lo = a_small ? coef_a_reg : coef_b_reg;
    wire [15:0] coef_hi = a_small ? coef_b_reg : coef_a_reg;
    // Deviation spans -100..100, set point 0..100 or the coefficient bounds when both are set
    wire [15:0] sp_lo = act_dev ? `PCT_MIN : (coef_mode ? coef_lo : 16'h0000);
    wire [15:0] sp_hi = act_dev ? `PCT_MAX : (coef_mode ? coef_hi : `PCT_MAX);
    wire [15:0] mv_lo = coef_mode ? coef_lo : 16'h0000;
    wire [15:0] mv_hi = coef_mode ? coef_hi : `PCT_MAX;
    wire [15:0] mv_sat;

    pid_saturate #(.W(16)) u_sat_sp (
        .value_in(pid_setpoint_reg),
        .lo_lim(sp_lo),
        .hi_lim(sp_hi),
        .value_out(pid_reference)
    );
    pid_saturate #(.W(16)) u_sat_mv (
        .value_in(pid_measured_reg),
        .lo_lim(mv_lo),
        .hi_lim(mv_hi),
        .value_out(mv_sat)
    );
    // Measured word is unused in deviation mode
    assign pid_feedback = act_dev ? 16'h0000 : mv_sat;
    wire [15:0] result_sat;
    pid_saturate #(.W(16)) u_sat_out (
        .value_in(pid_result),
        .lo_lim(`PCT_MIN),
        .hi_lim(`PCT_MAX),
        .value_out(result_sat)
    );

    // ----------------------------------------
    // AHB-Lite slave
    // ----------------------------------------
    // Zero wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    wire addr_phase = hsel && htrans[1] && hready;

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            hrdata <= 32'h00000000;
        end else begin
            wr_pend_reg <= addr_phase && hwrite;
            if (addr_phase) begin
                wr_addr_reg <= haddr[7:0];
            end
            if (addr_phase && !hwrite) begin
                case (haddr[7:0])
                    `OFS_PID_ACTION_SELECT: hrdata <= {16'h0000, pid_action_select_reg};
                    `OFS_PID_SETPOINT: hrdata <= {16'h0000, pid_setpoint_reg};
                    `OFS_PID_MEASURED: hrdata <= {16'h0000, pid_measured_reg};
                    `OFS_PID_OUTPUT: hrdata <= {16'h0000, pid_output_reg};
                    `OFS_PID_RUN_CONTROL: hrdata <= {16'h0000, pid_run_control_reg};
                    `OFS_FLASH_CLEAR: hrdata <= {16'h0000, flash_clear_reg};
                    `OFS_CONFIG: hrdata <= {15'h0000, scan_enable_reg, watchdog_quanta_reg};
                    `OFS_COEF_BOUNDS: hrdata <= {coef_b_reg, coef_a_reg};
                    `OFS_SCAN_SETTING: hrdata <= {16'h0000, scan_setting_reg};
                    `OFS_SCAN_STATUS: hrdata <= {write_disable_error, watchdog_error,
                        scan_overrun_error, scan_wait, erasing_reg, 11'h000,
                        scan_overrun_error ? `SCAN_OVERRUN_CODE : 16'h0000};
                    default: hrdata <= 32'h00000000;
                endcase
            end
        end
    end
    wire wr_en = wr_pend_reg;
    wire [15:0] wd = hwdata[15:0];

    // ----------------------------------------
    // Plain configuration registers
    // ----------------------------------------
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pid_action_select_reg <= `RST_ACTION;
            pid_setpoint_reg <= 16'h0000;
            pid_measured_reg <= 16'h0000;
            pid_run_control_reg <= 16'h0000;
            coef_a_reg <= `COEF_NONE;
            coef_b_reg <= `COEF_NONE;
            scan_setting_reg <= 16'h0000;
            watchdog_quanta_reg <= 16'h0014;
            scan_enable_reg <= 1'b0;
            err_clear_reg <= 1'b0;
            pid_output_reg <= 16'h0000;
        end else begin
            err_clear_reg <= 1'b0;
            if (wr_en) begin
                case (wr_addr_reg)
                    `OFS_PID_ACTION_SELECT: pid_action_select_reg <= wd;
                    `OFS_PID_SETPOINT: pid_setpoint_reg <= wd;
                    `OFS_PID_MEASURED: pid_measured_reg <= wd;
                    `OFS_PID_RUN_CONTROL: pid_run_control_reg <= wd;
                    `OFS_COEF_BOUNDS: begin
                        coef_a_reg <= hwdata[15:0];
                        coef_b_reg <= hwdata[31:16];
                    end
                    `OFS_SCAN_SETTING: scan_setting_reg <= wd;
                    `OFS_CONFIG: begin
                        watchdog_quanta_reg <= wd;
                        scan_enable_reg <= hwdata[16];
                    end
                    `OFS_SCAN_STATUS: err_clear_reg <= hwdata[29];
                    default: ;
                endcase
            end
            // Result stored only while pid_run and pid_result_valid are both high
            if (pid_run && pid_result_valid) begin
                pid_output_reg <= result_sat;
            end
        end
    end

    // ----------------------------------------
    // Flash-clear sequencer
    // ----------------------------------------
    wire fc_write = wr_en && wr_addr_reg == `OFS_FLASH_CLEAR;
    wire erase_timeout = erase_cnt_reg >= ERASE_CYC - 1;
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            flash_clear_reg <= `RST_FLASH;
            erasing_reg <= 1'b0;
            erase_cnt_reg <= 32'h00000000;
            flash_erase_req <= 1'b0;
            write_disable_error <= 1'b0;
            boot_cnt_reg <= 2'b00;
        end else begin
            // Strap needs two sync edges, so watch it for three
            if (boot_cnt_reg != 2'b11) begin
                boot_cnt_reg <= boot_cnt_reg + 2'b01;
            end
            if (boot_cnt_reg != 2'b11 && fault_s2_reg) begin
                flash_clear_reg <= `FLASH_CLEAR_KEY;
            end
            if (erasing_reg) begin
                erase_cnt_reg <= erase_cnt_reg + 1'b1;
                // Done strobe or 30 s bound ends it
                if (done_s2_reg || erase_timeout) begin
                    erasing_reg <= 1'b0;
                    flash_erase_req <= 1'b0;
                    flash_clear_reg <= `FLASH_IDLE;
                end
            end
            if (fc_write && !erasing_reg) begin
                if (wd == `FLASH_IDLE) begin
                    flash_clear_reg <= `FLASH_IDLE;
                    write_disable_error <= 1'b0;
                end else if (wd == `FLASH_CLEAR_KEY) begin
                    write_disable_error <= 1'b0;
                    if (sel_s2_reg != 2'b00) begin
                        flash_clear_reg <= `FLASH_REFUSED;
                    end else if (flash_clear_reg != `FLASH_CLEAR_KEY) begin
                        flash_clear_reg <= `FLASH_CLEAR_KEY;
                        erasing_reg <= 1'b1;
                        flash_erase_req <= 1'b1;
                        erase_cnt_reg <= 32'h00000000;
                    end
                end else begin
                    write_disable_error <= 1'b1;
                end
            end
        end
    end

    // ----------------------------------------
    // Constant-scan pacer
    // ----------------------------------------
    scan_pacer #(.QUANTUM_CYC(QUANTUM_CYC), .CW(32)) u_pacer (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .scan_setting(scan_setting_reg),
        .watchdog_quanta(watchdog_quanta_reg),
        .scan_enable(scan_enable_reg),
        .scan_start(scan_start),
        .scan_end(scan_end),
        .err_clear(err_clear_reg),
        .scan_wait(scan_wait),
        .scan_overrun_error(scan_overrun_error),
        .watchdog_error(watchdog_error),
        .last_scan_cyc(last_scan_cyc)
    );
endmodule // plc_pid_flash_scan_ctrl
`default_nettype wire

//--- sim/plc_pid_checker_assertions.sv
// Purpose: Port-level checks for plc_pid_flash_scan_ctrl
// Assumes: One clock domain
// Notes: Sees top ports only
`timescale 1ns/1ps
`default_nettype none
module plc_pid_checker #(
    parameter ERASE_CYC = 200
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic flash_erase_done,
    input wire logic [15:0] pid_reference,
    input wire logic [15:0] pid_feedback,
    input wire logic pid_deviation_mode,
    input wire logic flash_erase_req,
    input wire logic write_disable_error,
    input wire logic scan_end,
    input wire logic scan_wait,
    input wire logic scan_overrun_error
);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    logic [31:0] erase_cnt_reg;
    wire addr_wr = hsel && htrans[1] && hwrite;
    // Erase length counter
    always_ff @(posedge sys_clk or negedge rst_n)
        erase_cnt_reg <= (!rst_n || !flash_erase_req) ? 32'h0 : erase_cnt_reg + 32'h1;
    sequence erase_ending_s;
        flash_erase_req && flash_erase_done;
    endsequence
    sequence overrun_held_s;
        scan_overrun_error [*2];
    endsequence
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    erase_len_a: assert property (erase_cnt_reg <= ERASE_CYC + 8)
        else $error("erase too long");
    erase_cause_a: assert property ($rose(flash_erase_req) |->
        $past(hwdata[15:0]) == 16'h25E0 || $past(hwdata[15:0], 2) == 16'h25E0)
        else $error("erase without key write");
    erase_end_a: assert property (erase_ending_s |-> ##[1:4] !flash_erase_req)
        else $error("erase not ended by done");
    dev_feedback_a: assert property (pid_deviation_mode |-> pid_feedback == 16'h0)
        else $error("feedback used in deviation mode");
    dev_range_a: assert property (pid_deviation_mode |->
        $signed(pid_reference) <= 10000 && $signed(pid_reference) >= -10000)
        else $error("deviation not saturated");
    wde_cause_a: assert property ($changed(write_disable_error) |->
        $past(addr_wr, 2) || $past(addr_wr, 3))
        else $error("error flag moved without write");
    wait_cause_a: assert property ($rose(scan_wait) |->
        $past(scan_end) || $past(scan_end, 2))
        else $error("wait without scan end");
    overrun_pad_a: assert property (overrun_held_s |-> !scan_wait)
        else $error("padding during overrun");
endmodule // plc_pid_checker
bind plc_pid_flash_scan_ctrl plc_pid_checker #(.ERASE_CYC(ERASE_CYC)) chk (
    .sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
    .hwdata(hwdata), .flash_erase_done(flash_erase_done), .pid_reference(pid_reference),
    .pid_feedback(pid_feedback), .pid_deviation_mode(pid_deviation_mode),
    .flash_erase_req(flash_erase_req), .write_disable_error(write_disable_error),
    .scan_end(scan_end), .scan_wait(scan_wait), .scan_overrun_error(scan_overrun_error));
`default_nettype wire

//--- sim/tb_top.sv
// Purpose: Self-checking bench for plc_pid_flash_scan_ctrl
// Assumes: Shortened erase and quantum counts
// Notes: Reads queue their expected word; a watcher compares
`timescale 1ns/1ps
`default_nettype none
`include "plc_pid_defines.vh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_count++; \
    $display("unexpected at %0t: %h vs %h", $time, g, e); end end
module tb_top;
    logic sys_clk = 0, rst_n = 0, hsel = 0, hwrite = 0, pid_enable_input = 0;
    logic enable_terminal_assigned = 0, flash_fault_at_boot = 0, flash_erase_done = 0;
    logic pid_result_valid = 0, scan_start = 0, scan_end = 0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, got, exp_w;
    logic [31:0] exp_q[$];
    logic [1:0] htrans = 2'h0, controller_function_select = 2'h0;
    logic [15:0] pid_result = 16'h0;
    wire hreadyout, hresp, pid_run, pid_reverse, pid_deviation_mode, pid_apply_to_freq;
    wire flash_erase_req, write_disable_error, scan_wait, scan_overrun_error, watchdog_error;
    wire [31:0] hrdata;
    wire [15:0] pid_reference, pid_feedback;
    int err_count = 0, comparisons = 0, seed = 25, v;
    int codes[8] = '{1000, 1001, 1010, 1011, 2000, 2001, 2010, 2011};
    int sets[4] = '{1, 20, 21, 40};
    event rd_done;
    localparam FC = `OFS_FLASH_CLEAR, KEY = `FLASH_CLEAR_KEY;
    plc_pid_flash_scan_ctrl #(.ERASE_CYC(200), .QUANTUM_CYC(10)) dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .pid_enable_input(pid_enable_input), .enable_terminal_assigned(enable_terminal_assigned),
        .controller_function_select(controller_function_select),
        .flash_fault_at_boot(flash_fault_at_boot), .flash_erase_done(flash_erase_done),
        .pid_result(pid_result), .pid_result_valid(pid_result_valid), .scan_start(scan_start),
        .scan_end(scan_end), .pid_run(pid_run), .pid_reverse(pid_reverse),
        .pid_deviation_mode(pid_deviation_mode), .pid_apply_to_freq(pid_apply_to_freq),
        .pid_reference(pid_reference), .pid_feedback(pid_feedback),
        .flash_erase_req(flash_erase_req), .write_disable_error(write_disable_error),
        .scan_wait(scan_wait), .scan_overrun_error(scan_overrun_error),
        .watchdog_error(watchdog_error));
    // ----------------------------------------
    // Clock, watchdog, verdict
    // ----------------------------------------
    initial forever #20 sys_clk = ~sys_clk;
    // Sequence needs a few hundred cycles
    initial begin
        #2000000;
        err_count++;
        summarize();
    end
    task automatic summarize();
        $display("comparisons %0d err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // ----------------------------------------
    // Bus master and read watcher
    // ----------------------------------------
    // One single transfer
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge sys_clk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        @(posedge sys_clk);
        while (hreadyout !== 1'b1) @(posedge sys_clk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge sys_clk);
        while (hreadyout !== 1'b1) @(posedge sys_clk);
        got = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(a, 1'b1, d);
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1);
        exp_q.push_back(e & m);
        bus(a, 1'b0, 32'h0);
        got = got & m;
        -> rd_done;
    endtask
    initial forever begin
        @(rd_done);
        exp_w = exp_q.pop_front();
        `CHK(got, exp_w)
        `CHK({hresp, hreadyout}, 2'b01)
    end
    // Program scan
    task automatic scan(input int len);
        @(posedge sys_clk);
        scan_start <= 1'b1;
        @(posedge sys_clk);
        scan_start <= 1'b0;
        repeat (len - 1) @(posedge sys_clk);
        scan_end <= 1'b1;
        @(posedge sys_clk);
        scan_end <= 1'b0;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd(`OFS_PID_ACTION_SELECT, `RST_ACTION);
        rd(`OFS_FLASH_CLEAR, `RST_FLASH);
        rd(8'h28, 32'h0);
        foreach (codes[i]) begin
            wr(`OFS_PID_ACTION_SELECT, codes[i]);
            `CHK(pid_reverse, ~codes[i][0])
            `CHK(pid_deviation_mode, (codes[i] % 100) >= 10)
            `CHK(pid_apply_to_freq, codes[i] < 2000)
        end
        wr(`OFS_PID_ACTION_SELECT, 0);
        wr(`OFS_PID_RUN_CONTROL, 1);
        `CHK(pid_run, 1'b0)
        wr(`OFS_PID_ACTION_SELECT, 1000);
        `CHK(pid_run, 1'b1)
        wr(`OFS_PID_RUN_CONTROL, 0);
        `CHK(pid_run, 1'b0)
        wr(`OFS_PID_RUN_CONTROL, 3);
        `CHK(pid_run, 1'b1)
        @(posedge sys_clk);
        enable_terminal_assigned <= 1'b1;
        tick(4);
        `CHK(pid_run, 1'b0)
        pid_enable_input <= 1'b1;
        tick(4);
        `CHK(pid_run, 1'b1)
        v = $unsigned($random(seed)) % 10001;
        wr(`OFS_PID_SETPOINT, v);
        wr(`OFS_PID_MEASURED, 10000 - v);
        `CHK(pid_reference, v[15:0])
        `CHK(pid_feedback, 16'(10000 - v))
        wr(`OFS_PID_SETPOINT, 12000);
        wr(`OFS_PID_MEASURED, 32'hFFF6);
        `CHK(pid_reference, `PCT_MAX)
        `CHK(pid_feedback, 16'h0)
        wr(`OFS_COEF_BOUNDS, {16'd200, 16'd500});
        `CHK(pid_reference, 16'd500)
        wr(`OFS_PID_SETPOINT, 100);
        `CHK(pid_reference, 16'd200)
        wr(`OFS_COEF_BOUNDS, {`COEF_NONE, `COEF_NONE});
        wr(`OFS_PID_ACTION_SELECT, 1010);
        wr(`OFS_PID_SETPOINT, -12000);
        `CHK(pid_reference, `PCT_MIN)
        `CHK(pid_feedback, 16'h0)
        v = $random(seed) % 10001;
        @(posedge sys_clk);
        pid_result <= v[15:0];
        pid_result_valid <= 1'b1;
        @(posedge sys_clk);
        pid_result_valid <= 1'b0;
        rd(`OFS_PID_OUTPUT, {16'h0, v[15:0]}, 32'hFFFF);
        wr(`OFS_PID_OUTPUT, 32'h55);
        rd(`OFS_PID_OUTPUT, {16'h0, v[15:0]}, 32'hFFFF);
        // Scan: 0.5 ms units, quantum 10 cycles
        wr(`OFS_CONFIG, 32'h00010014);
        foreach (sets[i]) begin
            wr(`OFS_SCAN_SETTING, sets[i]);
            scan(2);
            tick(((sets[i] + 19) / 20) * 10 - 6);
            `CHK(scan_wait, 1'b1)
            tick(7);
            `CHK(scan_wait, 1'b0)
        end
        wr(`OFS_SCAN_SETTING, 20);
        scan(15);
        tick(1);
        `CHK(scan_overrun_error, 1'b1)
        rd(`OFS_SCAN_STATUS, 32'h20001392, 32'h2000FFFF);
        scan(2);
        tick(2);
        `CHK(scan_wait, 1'b0)
        wr(`OFS_SCAN_STATUS, 32'h20000000);
        wr(`OFS_CONFIG, 32'h00010002);
        scan(30);
        tick(1);
        `CHK(watchdog_error, 1'b1)
        // Flash clear
        controller_function_select <= 2'h1;
        tick(4);
        wr(FC, KEY);
        `CHK(flash_erase_req, 1'b0)
        rd(FC, `FLASH_REFUSED);
        controller_function_select <= 2'h0;
        tick(4);
        wr(FC, 0);
        rd(FC, `FLASH_IDLE);
        wr(FC, KEY);
        `CHK(flash_erase_req, 1'b1)
        rd(FC, KEY);
        wr(FC, KEY);
        `CHK(flash_erase_req, 1'b1)
        flash_erase_done <= 1'b1;
        tick(1);
        flash_erase_done <= 1'b0;
        tick(5);
        `CHK(flash_erase_req, 1'b0)
        rd(FC, `FLASH_IDLE);
        wr(FC, 5);
        `CHK(write_disable_error, 1'b1)
        rd(FC, `FLASH_IDLE);
        // Reset mid-erase, then retry
        wr(FC, KEY);
        flash_fault_at_boot <= 1'b1;
        rst_n <= 1'b0;
        tick(2);
        rst_n <= 1'b1;
        tick(8);
        rd(FC, KEY);
        flash_fault_at_boot <= 1'b0;
        wr(FC, 0);
        rd(FC, `FLASH_IDLE);
        wr(FC, KEY);
        `CHK(flash_erase_req, 1'b1)
        flash_erase_done <= 1'b1;
        tick(6);
        summarize();
    end
endmodule // tb_top
`default_nettype wire
